// file: bsrp_pkg.sv
/*
 * Shared constants for the backlight two-wire register port: device address,
 * register indices, reset values, field positions and link timing.
 * Assumes a single 40 MHz core clock on both ends of the link.
 */
package bsrp_pkg;
    localparam logic [7:0] DEV_ADDR_WR = 8'h58;
    localparam logic [7:0] DEV_ADDR_RD = 8'h59;
    localparam logic [3:0] ADDR_CLASS = 4'h5;
    localparam int ADDR_CLASS_MSB = 7;
    localparam int ADDR_CLASS_LSB = 4;
    localparam int ADDR_FIXED_BIT = 3;
    localparam int RW_BIT = 0;

    localparam logic [7:0] IDX_PWM = 8'h00;
    localparam logic [7:0] IDX_CTRL = 8'h01;
    localparam logic [7:0] IDX_FAULT = 8'h02;
    localparam logic [7:0] IDX_REV = 8'h03;
    localparam logic [7:0] IDX_DC = 8'h07;
    localparam logic [7:0] IDX_CONFIG = 8'h08;
    localparam logic [7:0] IDX_CHAN = 8'h09;
    localparam logic [7:0] IDX_PHASE = 8'h0a;
    localparam logic [7:0] IDX_SYNC = 8'h0b;

    localparam logic [7:0] RST_PWM = 8'hff;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_DC = 8'hff;
    localparam logic [7:0] RST_CONFIG = 8'h1f;
    localparam logic [7:0] RST_CHAN = 8'h3f;
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] RST_SYNC = 8'h10;
    localparam logic [7:0] CTRL_WMASK = 8'h3f;
    localparam logic [7:0] CHAN_WMASK = 8'h3f;

    localparam int CTRL_BL_ON = 0;
    localparam int CTRL_EXT_DIM = 1;
    localparam int CTRL_HOST_DIM = 2;
    localparam logic [7:0] PWM_LAST_STEP = 8'hfe;

    localparam int CLK_PERIOD_NS = 25;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

    localparam logic [3:0] HOST_OFS_CMD = 4'h0;
    localparam logic [3:0] HOST_OFS_STATUS = 4'h4;
    localparam int HCMD_RD_BIT = 16;
    localparam int HST_BUSY_BIT = 0;
    localparam int HST_NACK_BIT = 1;
endpackage

// file: bsrp_link_if.sv
/*
 * Two-wire link between the host end and the device end.
 * Both lines are open drain with a pull-up; each party gives value and enable.
 */
`timescale 1ns/100ps
`default_nettype none
interface bsrp_link_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // pull-up wins unless an enabled driver pulls low
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// file: bsrp_device.sv
/*
 * Device end: two-wire target at a fixed address with the byte-wide
 * backlight register bank, brightness selection and PWM dimming output.
 * Assumes the host drives SCL slowly relative to the core clock
 * (several core clocks per SCL phase) and changes SDA only while SCL is low.
 */
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - write is address, command code, data byte
// - completed write stores data at command index
// - read: address, command, repeated start, read byte
// - returned byte is indexed register's current content
// - device drives SDA only for acks, read data
// - address byte: 7-bit address, bit0 read flag
// - answer only class 0101 with bit3 set
// - address bytes are 0x58 write, 0x59 read
// - eight-bit registers, single-byte access only
// - reserved bits reset to zero
// - PWM register gives 256 duty levels
// - host-dimming bit selects register brightness
// - external-dimming bit selects external PWM input
// - bit0 switches backlight, resets off
// - fault bit0 is OR of fault flags
// - PWM write applies only in host mode
module bsrp_device #(
    parameter logic [7:0] REVISION_CODE = 8'h12 // arbitrary value
) (
    input wire logic clock,
    input wire logic rst,
    bsrp_link_if.dev link,
    input wire logic two_channels_off_flag,
    input wire logic one_channel_off_flag,
    input wire logic backlight_state_flag,
    input wire logic input_overcurrent_flag,
    input wire logic thermal_trip_flag,
    input wire logic external_dim_select_in,
    output logic pwm_dim_out,
    output logic backlight_on,
    output logic [7:0] applied_duty_level,
    output logic [7:0] dc_current_level,
    output logic [7:0] driver_config,
    output logic [7:0] channel_enable,
    output logic [7:0] phase_offset,
    output logic [7:0] sync_divider
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_SKIP} bsrp_dev_state_e;

    bsrp_dev_state_e state_ff;
    logic [2:0] scl_sync_ff;
    logic [2:0] sda_sync_ff;
    logic [7:0] fault_s1_ff;
    logic [7:0] fault_s2_ff;
    logic [1:0] ext_sync_ff;
    logic [3:0] bitcnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] cmd_ff;
    logic [7:0] tx_ff;
    logic is_read_ff;
    logic sda_oe_ff;
    logic [7:0] pwm_duty_level_ff;
    logic [7:0] ctrl_ff;
    logic [7:0] dc_ff;
    logic [7:0] config_ff;
    logic [7:0] chan_ff;
    logic [7:0] phase_ff;
    logic [7:0] sync_ff;
    logic [7:0] applied_ff;
    logic [7:0] pwm_cnt_ff;
    logic dim_ff;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic addr_hit;
    logic commit_wr;
    logic [7:0] fault_byte;
    logic [7:0] rd_byte;

    // only bits 2 and 1 of sync stages feed logic; stage 0 is the catching flop
    assign scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
    assign scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
    assign start_seen = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[2] & ~sda_sync_ff[1];
    assign stop_seen = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[2] & sda_sync_ff[1];
    localparam int ADDR_MSB = bsrp_pkg::ADDR_CLASS_MSB;
    localparam int ADDR_LSB = bsrp_pkg::ADDR_CLASS_LSB;
    // class nibble and bit 3 are checked, and bits 7:1 must also equal the whole fixed 7-bit address
    assign addr_hit = (shift_ff[ADDR_MSB:ADDR_LSB] == bsrp_pkg::ADDR_CLASS)
        && shift_ff[bsrp_pkg::ADDR_FIXED_BIT]
        && (shift_ff[7:1] == bsrp_pkg::DEV_ADDR_WR[7:1]);
    assign commit_wr = scl_fall && (bitcnt_ff == 4'd8) && (state_ff == ST_WDATA);
    // fault byte: bit0 is the summary of the five flags
    assign fault_byte = {fault_s2_ff[7:1], |fault_s2_ff[5:1]};

    function automatic logic [7:0] reg_read(input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            bsrp_pkg::IDX_PWM: v = pwm_duty_level_ff;
            bsrp_pkg::IDX_CTRL: v = ctrl_ff;
            bsrp_pkg::IDX_FAULT: v = fault_byte;
            bsrp_pkg::IDX_REV: v = REVISION_CODE;
            bsrp_pkg::IDX_DC: v = dc_ff;
            bsrp_pkg::IDX_CONFIG: v = config_ff;
            bsrp_pkg::IDX_CHAN: v = chan_ff;
            bsrp_pkg::IDX_PHASE: v = phase_ff;
            bsrp_pkg::IDX_SYNC: v = sync_ff;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // always_comb also follows the registers read inside the function; a plain assign would not
    always_comb begin
        rd_byte = reg_read(cmd_ff);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            ext_sync_ff <= 2'h0;
            fault_s1_ff <= 8'h00;
            fault_s2_ff <= 8'h00;
        end else begin
            scl_sync_ff <= {scl_sync_ff[1:0], link.scl};
            sda_sync_ff <= {sda_sync_ff[1:0], link.sda};
            ext_sync_ff <= {ext_sync_ff[0], external_dim_select_in};
            fault_s1_ff <= {2'b00, two_channels_off_flag, one_channel_off_flag, backlight_state_flag,
                input_overcurrent_flag, thermal_trip_flag, 1'b0};
            fault_s2_ff <= fault_s1_ff;
        end
    end

    // protocol engine: bits are taken on SCL rise, SDA is changed on SCL fall
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            bitcnt_ff <= 4'd0;
            shift_ff <= 8'h00;
            cmd_ff <= 8'h00;
            tx_ff <= 8'h00;
            is_read_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (start_seen) begin
            state_ff <= ST_ADDR;
            bitcnt_ff <= 4'd0;
            sda_oe_ff <= 1'b0;
        end else if (stop_seen) begin
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (state_ff != ST_IDLE && state_ff != ST_SKIP) begin
            if (scl_rise) begin
                if (bitcnt_ff < 4'd8) begin
                    shift_ff <= {shift_ff[6:0], sda_sync_ff[2]};
                end
                bitcnt_ff <= bitcnt_ff + 4'd1;
            end else if (scl_fall) begin
                if (bitcnt_ff == 4'd8) begin
                    unique case (state_ff)
                        ST_ADDR: begin
                            sda_oe_ff <= addr_hit;
                            is_read_ff <= shift_ff[bsrp_pkg::RW_BIT];
                            if (!addr_hit) begin
                                state_ff <= ST_SKIP;
                            end
                        end
                        ST_CMD: begin
                            cmd_ff <= shift_ff;
                            sda_oe_ff <= 1'b1;
                        end
                        ST_WDATA: sda_oe_ff <= 1'b1;
                        ST_RDATA: sda_oe_ff <= 1'b0;
                        default: sda_oe_ff <= 1'b0;
                    endcase
                end else if (bitcnt_ff == 4'd9) begin
                    bitcnt_ff <= 4'd0;
                    sda_oe_ff <= 1'b0;
                    unique case (state_ff)
                        ST_ADDR: begin
                            if (is_read_ff) begin
                                state_ff <= ST_RDATA;
                                tx_ff <= rd_byte;
                                sda_oe_ff <= ~rd_byte[7];
                            end else begin
                                state_ff <= ST_CMD;
                            end
                        end
                        ST_CMD: state_ff <= ST_WDATA;
                        // one data byte per transaction; further bytes are not acked
                        default: state_ff <= ST_SKIP;
                    endcase
                end else if (state_ff == ST_RDATA) begin
                    sda_oe_ff <= ~tx_ff[3'd7 - bitcnt_ff[2:0]];
                end
            end
        end
    end

    // register bank; reserved bits cannot be written so they stay zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwm_duty_level_ff <= bsrp_pkg::RST_PWM;
            ctrl_ff <= bsrp_pkg::RST_CTRL;
            dc_ff <= bsrp_pkg::RST_DC;
            config_ff <= bsrp_pkg::RST_CONFIG;
            chan_ff <= bsrp_pkg::RST_CHAN;
            phase_ff <= bsrp_pkg::RST_PHASE;
            sync_ff <= bsrp_pkg::RST_SYNC;
        end else if (commit_wr) begin
            unique case (cmd_ff)
                bsrp_pkg::IDX_PWM: pwm_duty_level_ff <= shift_ff;
                bsrp_pkg::IDX_CTRL: ctrl_ff <= shift_ff & bsrp_pkg::CTRL_WMASK;
                bsrp_pkg::IDX_DC: dc_ff <= shift_ff;
                bsrp_pkg::IDX_CONFIG: config_ff <= shift_ff;
                bsrp_pkg::IDX_CHAN: chan_ff <= shift_ff & bsrp_pkg::CHAN_WMASK;
                bsrp_pkg::IDX_PHASE: phase_ff <= shift_ff;
                bsrp_pkg::IDX_SYNC: sync_ff <= shift_ff;
                default: ;
            endcase
        end
    end

    // applied level only follows the register in host dimming mode, so a
    // write made under external control is stored but not yet shown
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            applied_ff <= bsrp_pkg::RST_PWM;
        end else if (ctrl_ff[bsrp_pkg::CTRL_HOST_DIM] && !ctrl_ff[bsrp_pkg::CTRL_EXT_DIM]) begin
            applied_ff <= pwm_duty_level_ff;
        end
    end

    // 255-clock frame: level 0 is off, level 255 is always on
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwm_cnt_ff <= 8'h00;
            dim_ff <= 1'b0;
        end else begin
            pwm_cnt_ff <= (pwm_cnt_ff == bsrp_pkg::PWM_LAST_STEP) ? 8'h00 : pwm_cnt_ff + 8'h01;
            if (!ctrl_ff[bsrp_pkg::CTRL_BL_ON]) begin
                dim_ff <= 1'b0;
            end else if (ctrl_ff[bsrp_pkg::CTRL_EXT_DIM]) begin
                dim_ff <= ext_sync_ff[1];
            end else if (ctrl_ff[bsrp_pkg::CTRL_HOST_DIM]) begin
                dim_ff <= pwm_cnt_ff < applied_ff;
            end else begin
                dim_ff <= 1'b0;
            end
        end
    end

    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe = sda_oe_ff;
    assign pwm_dim_out = dim_ff;
    assign backlight_on = ctrl_ff[bsrp_pkg::CTRL_BL_ON];
    assign applied_duty_level = applied_ff;
    assign dc_current_level = dc_ff;
    assign driver_config = config_ff;
    assign channel_enable = chan_ff;
    assign phase_offset = phase_ff;
    assign sync_divider = sync_ff;
endmodule
`default_nettype wire

// file: bsrp_host.sv
/*
 * Host end: two-wire master that runs one Write Byte or Read Byte
 * transaction per command, ordered by software over Avalon-MM.
 * Assumes the device end shares the core clock rate and pulls up both lines.
 */
`timescale 1ns/100ps
`default_nettype none
module bsrp_host #(
    parameter int QUARTER_CYC = bsrp_pkg::SCL_QUARTER_CYC
) (
    input wire logic clock,
    input wire logic rst,
    bsrp_link_if.host link,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BITS, HS_STOP} bsrp_host_state_e;

    // the device needs a few clocks per phase, and the quarter counter is 16 bits wide
    if (QUARTER_CYC < 4 || QUARTER_CYC > 65536) begin : g_bad_quarter
        $error("QUARTER_CYC out of range");
    end

    bsrp_host_state_e state_ff;
    logic [15:0] qcnt_ff;
    logic [1:0] quarter_ff;
    logic [3:0] bit_ff;
    logic [1:0] byte_ff;
    logic [7:0] idx_ff;
    logic [7:0] wdata_ff;
    logic [7:0] rdata_ff;
    logic rd_ff;
    logic nack_ff;
    logic scl_low_ff;
    logic sda_low_ff;
    logic [1:0] sda_sync_ff;
    logic wait_ff;
    logic [31:0] rdbus_ff;
    logic tick;
    logic rx_byte;
    logic [7:0] tx_byte;

    assign tick = (qcnt_ff == 16'(QUARTER_CYC - 1));
    assign rx_byte = rd_ff && (byte_ff == 2'd3);
    always_comb begin
        unique case (byte_ff)
            2'd0: tx_byte = bsrp_pkg::DEV_ADDR_WR;
            2'd1: tx_byte = idx_ff;
            2'd2: tx_byte = rd_ff ? bsrp_pkg::DEV_ADDR_RD : wdata_ff;
            default: tx_byte = 8'hff;
        endcase
    end

    // request taken at the second edge: waitrequest drops for one cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_ff <= 1'b1;
            rdbus_ff <= 32'h0000_0000;
        end else if ((avs_read || avs_write) && wait_ff) begin
            wait_ff <= 1'b0;
            rdbus_ff <= (avs_address == bsrp_pkg::HOST_OFS_STATUS) ?
                {16'h0000, rdata_ff, 6'h00, nack_ff, state_ff != HS_IDLE} : 32'h0000_0000;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sda_sync_ff <= 2'h3;
        end else begin
            sda_sync_ff <= {sda_sync_ff[0], link.sda};
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= HS_IDLE;
            qcnt_ff <= 16'h0000;
            quarter_ff <= 2'd0;
            bit_ff <= 4'd0;
            byte_ff <= 2'd0;
            idx_ff <= 8'h00;
            wdata_ff <= 8'h00;
            rdata_ff <= 8'h00;
            rd_ff <= 1'b0;
            nack_ff <= 1'b0;
            scl_low_ff <= 1'b0;
            sda_low_ff <= 1'b0;
        end else if (state_ff == HS_IDLE) begin
            qcnt_ff <= 16'h0000;
            quarter_ff <= 2'd0;
            if (avs_write && !wait_ff && avs_address == bsrp_pkg::HOST_OFS_CMD) begin
                idx_ff <= avs_writedata[7:0];
                wdata_ff <= avs_writedata[15:8];
                rd_ff <= avs_writedata[bsrp_pkg::HCMD_RD_BIT];
                nack_ff <= 1'b0;
                byte_ff <= 2'd0;
                state_ff <= HS_START;
            end
        end else begin
            qcnt_ff <= tick ? 16'h0000 : qcnt_ff + 16'h0001;
            if (tick) begin
                quarter_ff <= quarter_ff + 2'd1;
                unique case (state_ff)
                    HS_START: begin
                        unique case (quarter_ff)
                            2'd0: sda_low_ff <= 1'b0;
                            2'd1: scl_low_ff <= 1'b0;
                            2'd2: sda_low_ff <= 1'b1;
                            default: begin
                                scl_low_ff <= 1'b1;
                                bit_ff <= 4'd0;
                                state_ff <= HS_BITS;
                            end
                        endcase
                    end
                    HS_BITS: begin
                        unique case (quarter_ff)
                            // ack slot: host always releases; after read data this release is its nack
                            2'd0: sda_low_ff <= (bit_ff == 4'd8) ? 1'b0 : (!rx_byte && !tx_byte[3'd7 - bit_ff[2:0]]);
                            2'd1: scl_low_ff <= 1'b0;
                            2'd2: begin
                                if (bit_ff < 4'd8 && rx_byte) begin
                                    rdata_ff <= {rdata_ff[6:0], sda_sync_ff[1]};
                                end else if (bit_ff == 4'd8 && !rx_byte && sda_sync_ff[1]) begin
                                    nack_ff <= 1'b1;
                                end
                            end
                            default: begin
                                scl_low_ff <= 1'b1;
                                bit_ff <= bit_ff + 4'd1;
                                if (bit_ff == 4'd8) begin
                                    bit_ff <= 4'd0;
                                    byte_ff <= byte_ff + 2'd1;
                                    if (nack_ff || rx_byte || (!rd_ff && byte_ff == 2'd2)) begin
                                        state_ff <= HS_STOP;
                                    end else if (rd_ff && byte_ff == 2'd1) begin
                                        state_ff <= HS_START;
                                    end
                                end
                            end
                        endcase
                    end
                    default: begin
                        unique case (quarter_ff)
                            2'd0: sda_low_ff <= 1'b1;
                            2'd1: scl_low_ff <= 1'b0;
                            2'd2: sda_low_ff <= 1'b0;
                            default: state_ff <= HS_IDLE;
                        endcase
                    end
                endcase
            end
        end
    end

    assign link.host_scl_o = 1'b0;
    assign link.host_scl_oe = scl_low_ff;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe = sda_low_ff;
    assign avs_readdata = rdbus_ff;
    assign avs_waitrequest = wait_ff;
endmodule
`default_nettype wire

// file: bsrp_link_checker.sv
/*
 * Checker for the two-wire link between host end and device end.
 * Assumes the link interface signals and the core clock and reset are wired in.
 */
`timescale 1ns/100ps
`default_nettype none
module bsrp_link_checker #(
    parameter int QUARTER_CYC = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    int unsigned drive_cnt_ff;
    int unsigned high_cnt_ff;
    // one ack plus a full read byte is the longest legal hold
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drive_cnt_ff <= 0;
        end else begin
            drive_cnt_ff <= dev_sda_oe ? drive_cnt_ff + 1 : 0;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            high_cnt_ff <= 0;
        end else begin
            high_cnt_ff <= scl ? high_cnt_ff + 1 : 0;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_reset_lines_free: assert property ($fell(rst) |-> !dev_sda_oe && !host_sda_oe && !host_scl_oe)
        else $error("line driven right after reset");
    a_open_drain_low: assert property ((dev_sda_oe || host_sda_oe || host_scl_oe) |->
        !dev_sda_o && !host_sda_o && !host_scl_o)
        else $error("line driven high");
    a_dev_change_low: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
        else $error("device changed data with clock high");
    a_no_dev_framing: assert property (scl && $past(scl) && $changed(sda) |->
        !dev_sda_oe && !$past(dev_sda_oe))
        else $error("device took part in start or stop");
    a_scl_high_min: assert property ($rose(scl) |-> scl[*6])
        else $error("clock high phase too short");
    a_scl_low_min: assert property ($fell(scl) |-> !scl[*6])
        else $error("clock low phase too short");
    a_drive_bounded: assert property (dev_sda_oe |-> drive_cnt_ff < 40 * QUARTER_CYC)
        else $error("device holds data line too long");
    a_idle_released: assert property (high_cnt_ff > 4 * QUARTER_CYC |-> !dev_sda_oe)
        else $error("device drives idle link");
endmodule
`default_nettype wire

// file: bsrp_tb.sv
/*
 * Testbench: host and device ends joined by the link, driven over Avalon-MM.
 * Assumes the host command and status offsets of the package.
 */
`timescale 1ns/100ps
`default_nettype none
module bsrp_tb;
    localparam int QC = 8;
    localparam logic [7:0] REV = 8'h3a; // arbitrary revision value
    localparam logic [7:0] IDX [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
    localparam logic [7:0] RST [9] = '{8'hff, 8'h00, 8'h00, REV, 8'hff, 8'h1f, 8'h3f, 8'h00, 8'h10};
    localparam logic [7:0] MSK [9] = '{8'hff, 8'h3f, 8'h00, 8'h00, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
    localparam logic [7:0] LVL [4] = '{8'h00, 8'h40, 8'hfe, 8'hff};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, st;
    logic avs_waitrequest, pwm_dim_out, backlight_on;
    logic [4:0] flags = 5'h00;
    logic external_dim_select_in = 1'b0;
    logic [7:0] applied_duty_level, dc_current_level, driver_config, channel_enable, phase_offset, sync_divider, rd;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    int cnt;
    bsrp_link_if lnk();
    always #12.5 clock = ~clock;
    bsrp_host #(.QUARTER_CYC(QC)) i_bsrp_host (.clock, .rst, .link(lnk), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest);
    bsrp_device #(.REVISION_CODE(REV)) i_bsrp_device (.clock, .rst, .link(lnk), .two_channels_off_flag(flags[4]),
        .one_channel_off_flag(flags[3]), .backlight_state_flag(flags[2]), .input_overcurrent_flag(flags[1]),
        .thermal_trip_flag(flags[0]), .external_dim_select_in, .pwm_dim_out, .backlight_on, .applied_duty_level,
        .dc_current_level, .driver_config(driver_config), .channel_enable, .phase_offset, .sync_divider);
    bsrp_link_checker #(.QUARTER_CYC(QC)) i_bsrp_link_checker (.clock, .rst, .host_scl_o(lnk.host_scl_o),
        .host_scl_oe(lnk.host_scl_oe), .host_sda_o(lnk.host_sda_o), .host_sda_oe(lnk.host_sda_oe),
        .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe(lnk.dev_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
    task automatic report_and_stop();
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // waitrequest and readdata are read as they stood at the rising edge, before that edge updates them
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic link_op(input logic is_rd, input logic [7:0] idx, input logic [7:0] d);
        av_xfer(1'b1, bsrp_pkg::HOST_OFS_CMD, {15'h0000, is_rd, d, idx}, st);
        do av_xfer(1'b0, bsrp_pkg::HOST_OFS_STATUS, 32'h0000_0000, st);
        while (st[bsrp_pkg::HST_BUSY_BIT] !== 1'b0);
        check(st[bsrp_pkg::HST_NACK_BIT], 1'b0);
        rd = st[15:8];
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check({backlight_on, pwm_dim_out, applied_duty_level}, 10'h0ff);
        for (int i = 0; i < 9; i++) begin
            link_op(1'b1, IDX[i], 8'h00);
            check(rd, RST[i]);
        end
        // inverted reset value flips every writable bit; read-only places must not move
        for (int i = 0; i < 9; i++) link_op(1'b0, IDX[i], ~RST[i]);
        for (int i = 0; i < 9; i++) begin
            link_op(1'b1, IDX[i], 8'h00);
            check(rd, RST[i] ^ MSK[i]);
        end
        check(applied_duty_level, 8'hff);
        check({backlight_on, dc_current_level, driver_config, channel_enable, phase_offset, sync_divider},
            41'h1_00e0_00ff_ef);
        for (int u = 0; u < 2; u++) begin
            link_op(1'b0, 8'h05 + 8'h0f * u[7:0], 8'h77);
            link_op(1'b1, 8'h05 + 8'h0f * u[7:0], 8'h00);
            check(rd, 8'h00);
        end
        for (int k = 0; k < 5; k++) begin
            @(posedge clock);
            flags <= 5'h01 << k;
            link_op(1'b1, bsrp_pkg::IDX_FAULT, 8'h00);
            check(rd, {2'b00, 5'h01 << k, 1'b1});
        end
        flags <= 5'h00;
        link_op(1'b0, bsrp_pkg::IDX_CTRL, 8'h03);
        link_op(1'b0, bsrp_pkg::IDX_PWM, 8'h80);
        link_op(1'b1, bsrp_pkg::IDX_PWM, 8'h00);
        check({rd, applied_duty_level}, 16'h80ff);
        for (int v = 1; v >= 0; v--) begin
            external_dim_select_in <= v[0];
            repeat (6) @(posedge clock);
            check(pwm_dim_out, v[0]);
        end
        link_op(1'b0, bsrp_pkg::IDX_CTRL, 8'h05);
        for (int j = 0; j < 4; j++) begin
            link_op(1'b0, bsrp_pkg::IDX_PWM, LVL[j]);
            check(applied_duty_level, LVL[j]);
            repeat (4) @(negedge clock);
            cnt = 0;
            repeat (255) @(negedge clock) cnt += int'(pwm_dim_out === 1'b1);
            check(cnt, LVL[j]);
        end
        link_op(1'b0, bsrp_pkg::IDX_CTRL, 8'h04);
        repeat (4) @(posedge clock);
        check({backlight_on, pwm_dim_out}, 2'b00);
        report_and_stop();
    end
endmodule
`default_nettype wire
